/* File: core/ocp_clock_ctrl.sv */
// Oscillator control, peripheral clock gating and PLL setup with AHB-Lite slave
//
// Implementation choice: register access over AHB-Lite.
`timescale 1ns/100ps
`default_nettype none

// Summary of operation
// R1 - Writing one stops that peripheral clock
// R2 - State bit reads one while clock runs
// R3 - Protected registers ignore writes under write protect
// R4 - Oscillator write needs key 0x37, else dropped
// R5 - Crystal stable flag after start-up interval
// R6 - Start-up interval is count times 8 slow
// R7 - Bypass sets crystal stable flag at once
// R8 - Enable and bypass clear resets stable flag
// R9 - Software never sets enable and bypass together
// R10 - Wait command one enters wait mode
// R11 - RC enable bit switches RC oscillator
// R12 - RC stable flag after RC start-up time
// R13 - RC frequency codes 4, 8, 12 MHz
// R14 - Source select: zero RC, one crystal
// R15 - Failure detector active only when enabled
// R16 - Measure main cycles over 16 slow periods
// R17 - Measurement valid only when oscillator running
// R18 - Software sets bit 29 on PLL writes
// R19 - PLL lock after lock count times 8
// R20 - Multiplier zero turns PLL off
// R21 - Divider zero gives no output, one bypasses
// R22 - Write-only reads return zero, no effects
// R23 - Peripheral bits 0 and 1 unimplemented
module ocp_clock_ctrl
   import ocp_pkg::*;
(
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic      [31:0] hrdata,
   output logic             hreadyout,
   output logic             hresp,
   input  wire logic        slow_clk_pin,
   input  wire logic        main_clk_pin,
   input  wire logic        write_protect_enable,
   input  wire logic [31:0] periph_enable_req,
   output logic      [31:0] periph_clock_run,
   output logic             crystal_osc_enable,
   output logic             crystal_osc_bypass,
   output logic             crystal_stable_flag,
   output logic             rc_osc_enable,
   output logic      [2:0]  rc_freq_select,
   output logic             rc_stable_flag,
   output logic             main_source_select,
   output logic             clock_fail_detect_enable,
   output logic             wait_command,
   output logic      [10:0] pll_multiplier,
   output logic      [7:0]  pll_divider,
   output logic             pll_lock_flag
);
   // ----------------------------------------
   // State
   // ----------------------------------------
   typedef struct packed {
      logic [31:0] pcs;
      logic        xt_en;
      logic        xt_by;
      logic        rc_en;
      logic [2:0]  rc_freq;
      logic [7:0]  xt_st;
      logic        msel;
      logic        cfd;
      logic        wait_p;
      logic [10:0] xt_cnt;
      logic        xt_ok;
      logic [10:0] rc_cnt;
      logic        rc_ok;
      logic [10:0] mul;
      logic [5:0]  pcount;
      logic [7:0]  div;
      logic        b29;
      logic [8:0]  pll_cnt;
      logic        lock;
      logic [2:0]  sl;
      logic        sl_lvl;
      logic [2:0]  ml;
      logic        ml_lvl;
      ocp_mf_t     mf_st;
      logic [15:0] mf_cnt;
      logic [3:0]  mf_per;
      logic [15:0] main_freq_count;
      logic        mf_ok;
      logic        wr_pend;
      ocp_sel_t    wr_sel;
      logic [31:0] rdata;
      logic        rdy;
   } ocp_state_t;

   ocp_state_t s;
   ocp_state_t next_s;
   logic       slow_tick;
   logic       main_tick;
   logic       main_on;
   logic       addr_ok;
   logic       wr_ok;
   logic       key_ok;
   ocp_sel_t   dec_sel;

   // ----------------------------------------
   // Address decode and read mux
   // ----------------------------------------
   always_comb begin
      case (haddr)
         ADDR_PCOFF: dec_sel = SEL_PCOFF;
         ADDR_PCST:  dec_sel = SEL_PCST;
         ADDR_MOR:   dec_sel = SEL_MOR;
         ADDR_MCFR:  dec_sel = SEL_MCFR;
         ADDR_PLL:   dec_sel = SEL_PLL;
         default:    dec_sel = SEL_NONE;
      endcase
   end

   function automatic logic [31:0] rd_mux(input ocp_sel_t sel, input ocp_state_t st);
      logic [31:0] r;
      r = 32'h0000_0000;
      case (sel)
         SEL_PCST: r = st.pcs & PERIPH_MASK; // R2 R23
         SEL_MOR:  r = {6'h00, st.cfd, st.msel, 8'h00, st.xt_st, 1'b0,
                        st.rc_freq, st.rc_en, 1'b0, st.xt_by, st.xt_en}; // R22
         SEL_MCFR: r = {15'h0000, st.mf_ok, st.main_freq_count};
         SEL_PLL:  r = {2'b00, st.b29, 2'b00, st.mul, 2'b00, st.pcount, st.div};
         default:  r = 32'h0000_0000; // R22
      endcase
      return r;
   endfunction

   // ----------------------------------------
   // Next state
   // ----------------------------------------
   always_comb begin
      next_s = s;
      addr_ok = hsel && htrans[1] && hready;
      wr_ok = s.wr_pend && !write_protect_enable; // R3
      key_ok = (hwdata[KEY_LSB +: 8] == MOR_KEY); // R4
      next_s.wait_p = 1'b0;
      next_s.rdy = 1'b1;
      // Pin synchronisers; a level counts once stages two and three agree
      next_s.sl = {s.sl[1:0], slow_clk_pin};
      next_s.ml = {s.ml[1:0], main_clk_pin};
      slow_tick = (s.sl[1] == s.sl[2]) && s.sl[2] && !s.sl_lvl;
      main_tick = (s.ml[1] == s.ml[2]) && s.ml[2] && !s.ml_lvl;
      if (s.sl[1] == s.sl[2]) begin
         next_s.sl_lvl = s.sl[2];
      end
      if (s.ml[1] == s.ml[2]) begin
         next_s.ml_lvl = s.ml[2];
      end

      // Crystal oscillator
      if (!s.xt_en && !s.xt_by) begin
         next_s.xt_ok = 1'b0; // R8
      end else if (s.xt_by) begin
         next_s.xt_ok = 1'b1; // R7
      end else if (s.xt_cnt == 11'h000) begin
         next_s.xt_ok = 1'b1; // R5
      end else if (slow_tick) begin
         next_s.xt_cnt = s.xt_cnt - 11'h001;
      end

      // RC oscillator
      if (!s.rc_en) begin
         next_s.rc_ok = 1'b0; // R11
      end else if (s.rc_cnt == 11'h000) begin
         next_s.rc_ok = 1'b1; // R12
      end else if (slow_tick) begin
         next_s.rc_cnt = s.rc_cnt - 11'h001;
      end

      // PLL lock counter
      if (s.pll_cnt == 9'h000) begin
         next_s.lock = 1'b1; // R19
      end else if (slow_tick) begin
         next_s.pll_cnt = s.pll_cnt - 9'h001;
      end

      // Main clock measurement
      main_on = s.msel ? s.xt_ok : s.rc_ok; // R14
      case (s.mf_st)
         MF_IDLE: begin
            if (main_on) begin
               next_s.mf_st = MF_WAIT;
            end
         end
         MF_WAIT: begin
            if (slow_tick) begin
               next_s.mf_cnt = 16'h0000;
               next_s.mf_per = 4'h0;
               next_s.mf_st = MF_RUN;
            end
         end
         MF_RUN: begin
            if (main_tick) begin
               next_s.mf_cnt = s.mf_cnt + 16'h0001;
            end
            if (slow_tick) begin
               next_s.mf_per = s.mf_per + 4'h1;
               if (s.mf_per == MF_LAST_PERIOD) begin
                  next_s.main_freq_count = next_s.mf_cnt; // R16
                  next_s.mf_ok = 1'b1;
                  next_s.mf_st = MF_WAIT;
               end
            end
         end
         default: next_s.mf_st = MF_IDLE;
      endcase
      if (!main_on) begin
         next_s.mf_ok = 1'b0; // R17
         next_s.mf_st = MF_IDLE;
      end

      // Bus address phase: reads have no side effect
      if (addr_ok) begin
         next_s.wr_pend = hwrite;
         next_s.wr_sel = dec_sel;
         next_s.rdata = hwrite ? 32'h0000_0000 : rd_mux(dec_sel, s); // R22
      end else begin
         next_s.wr_pend = 1'b0;
         next_s.wr_sel = SEL_NONE;
      end

      // Bus data phase: register writes
      if (wr_ok && s.wr_sel == SEL_PCOFF) begin
         next_s.pcs = s.pcs & ~(hwdata & PERIPH_MASK); // R1 R23
      end
      if (wr_ok && s.wr_sel == SEL_MOR && key_ok) begin // R3 R4
         next_s.xt_en = hwdata[XT_EN_BIT]; // R9
         next_s.xt_by = hwdata[XT_BY_BIT];
         next_s.rc_en = hwdata[RC_EN_BIT]; // R11
         next_s.rc_freq = hwdata[RCF_LSB +: 3]; // R13
         next_s.xt_st = hwdata[XTST_LSB +: 8];
         next_s.msel = hwdata[MSEL_BIT]; // R14
         next_s.cfd = hwdata[CFD_BIT]; // R15
         next_s.wait_p = hwdata[WAIT_BIT]; // R10
         if (hwdata[XT_EN_BIT] && !s.xt_en) begin
            next_s.xt_cnt = {hwdata[XTST_LSB +: 8], 3'b000}; // R6
            next_s.xt_ok = hwdata[XT_BY_BIT];
         end
         if (hwdata[RC_EN_BIT] && !s.rc_en) begin
            next_s.rc_cnt = RC_STARTUP_SLOW;
            next_s.rc_ok = 1'b0;
         end
      end
      if (wr_ok && s.wr_sel == SEL_PLL) begin // R3
         next_s.div = hwdata[DIV_LSB +: 8]; // R21
         next_s.pcount = hwdata[PCNT_LSB +: 6];
         next_s.mul = hwdata[MUL_LSB +: 11]; // R20
         next_s.b29 = hwdata[PLL_B29];
         next_s.pll_cnt = {hwdata[PCNT_LSB +: 6], 3'b000}; // R19
         next_s.lock = 1'b0;
      end
      // Enables from the companion enable register apply after a disable
      next_s.pcs = next_s.pcs | (periph_enable_req & PERIPH_MASK);
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         s <= '0;
         s.pcs <= PCS_RESET;
         s.xt_en <= MOR_RESET[XT_EN_BIT];
         s.xt_by <= MOR_RESET[XT_BY_BIT];
         s.rc_en <= MOR_RESET[RC_EN_BIT];
         s.pcount <= PLL_RESET[PCNT_LSB +: 6];
         s.pll_cnt <= PLL_CNT_RESET;
         s.mf_st <= MF_IDLE;
         s.wr_sel <= SEL_NONE;
         s.rdy <= 1'b1;
      end else begin
         s <= next_s;
      end
   end

   // ----------------------------------------
   // Outputs
   // ----------------------------------------
   assign hrdata = s.rdata;
   assign hreadyout = s.rdy;
   assign hresp = 1'b0;
   assign periph_clock_run = s.pcs; // R2
   assign crystal_osc_enable = s.xt_en;
   assign crystal_osc_bypass = s.xt_by;
   assign crystal_stable_flag = s.xt_ok;
   assign rc_osc_enable = s.rc_en; // R11
   assign rc_freq_select = s.rc_freq; // R13
   assign rc_stable_flag = s.rc_ok;
   assign main_source_select = s.msel;
   assign clock_fail_detect_enable = s.cfd; // R15
   assign wait_command = s.wait_p;
   assign pll_multiplier = s.mul; // R20
   assign pll_divider = s.div; // R21
   assign pll_lock_flag = s.lock;

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   property p_off_stops;
      (wr_ok && s.wr_sel == SEL_PCOFF) |=>
         ((periph_clock_run & $past(hwdata) & ~$past(periph_enable_req) & PERIPH_MASK) == 32'h0);
   endproperty
   a_off_stops: assert property (p_off_stops) else $error("disabled clock still runs"); // R1
   property p_state_read;
      (addr_ok && !hwrite && dec_sel == SEL_PCST) |=> (hrdata == $past(periph_clock_run));
   endproperty
   a_state_read: assert property (p_state_read) else $error("state read mismatch"); // R2
   property p_protect;
      (s.wr_pend && write_protect_enable && s.wr_sel != SEL_PCOFF) |=>
         ($stable(main_source_select) && $stable(pll_multiplier) && !wait_command);
   endproperty
   a_protect: assert property (p_protect) else $error("protected write applied"); // R3
   property p_bad_key;
      (s.wr_pend && s.wr_sel == SEL_MOR && !key_ok) |=>
         ($stable(rc_osc_enable) && $stable(clock_fail_detect_enable) && !wait_command);
   endproperty
   a_bad_key: assert property (p_bad_key) else $error("write with bad key applied"); // R4
   property p_xt_wait;
      ($rose(crystal_stable_flag) && !crystal_osc_bypass) |-> ($past(s.xt_cnt) == 11'h000);
   endproperty
   a_xt_wait: assert property (p_xt_wait) else $error("crystal flag before start-up"); // R5
   property p_bypass;
      (crystal_osc_bypass && !s.wr_pend) |=> crystal_stable_flag;
   endproperty
   a_bypass: assert property (p_bypass) else $error("bypass did not set flag"); // R7
   property p_xt_off;
      (!crystal_osc_enable && !crystal_osc_bypass && !s.wr_pend) |=> !crystal_stable_flag;
   endproperty
   a_xt_off: assert property (p_xt_off) else $error("flag kept with oscillator off"); // R8
   property p_wait;
      wait_command |-> ($past(wr_ok) && $past(s.wr_sel) == SEL_MOR && $past(hwdata[WAIT_BIT]));
   endproperty
   a_wait: assert property (p_wait) else $error("wait pulse without command"); // R10
   property p_mf_valid;
      !main_on |=> !s.mf_ok;
   endproperty
   a_mf_valid: assert property (p_mf_valid) else $error("measurement valid while off"); // R17
   property p_lock;
      (wr_ok && s.wr_sel == SEL_PLL) |=> !pll_lock_flag ##1 ($past(s.pll_cnt) != 9'h000 || pll_lock_flag);
   endproperty
   a_lock: assert property (p_lock) else $error("lock timing wrong"); // R19
   property p_wo_read;
      (addr_ok && !hwrite && dec_sel == SEL_PCOFF) |=> (hrdata == 32'h0);
   endproperty
   a_wo_read: assert property (p_wo_read) else $error("write-only read not zero"); // R22
   property p_unimpl;
      periph_clock_run[1:0] == 2'b00;
   endproperty
   a_unimpl: assert property (p_unimpl) else $error("unimplemented clock bit set"); // R23

   c_lock: cover property ($rose(pll_lock_flag));
   c_mf: cover property ($rose(s.mf_ok));
   c_xt: cover property (crystal_osc_enable ##1 $rose(crystal_stable_flag));
   c_off: cover property (wr_ok && s.wr_sel == SEL_PCOFF);

endmodule

`default_nettype wire

/* File: core/ocp_pkg.sv */
// Constants and types of the oscillator and peripheral clock controller
package ocp_pkg;
   // ----------------------------------------
   // Register byte addresses
   // ----------------------------------------
   localparam logic [31:0] ADDR_PCOFF = 32'h400E_0414;
   localparam logic [31:0] ADDR_PCST  = 32'h400E_0418;
   localparam logic [31:0] ADDR_MOR   = 32'h400E_0420;
   localparam logic [31:0] ADDR_MCFR  = 32'h400E_0424;
   localparam logic [31:0] ADDR_PLL   = 32'h400E_0428;
   // ----------------------------------------
   // Reset values and peripheral mask
   // ----------------------------------------
   localparam logic [31:0] PCS_RESET  = 32'h0000_0000;
   localparam logic [31:0] MOR_RESET  = 32'h0000_0001;
   localparam logic [31:0] PLL_RESET  = 32'h0000_3F00;
   localparam logic [31:0] PERIPH_MASK = 32'hFFFF_FFFC;
   // ----------------------------------------
   // Field positions and oscillator key
   // ----------------------------------------
   localparam int XT_EN_BIT  = 0;
   localparam int XT_BY_BIT  = 1;
   localparam int WAIT_BIT   = 2;
   localparam int RC_EN_BIT  = 3;
   localparam int RCF_LSB    = 4;
   localparam int XTST_LSB   = 8;
   localparam int KEY_LSB    = 16;
   localparam int MSEL_BIT   = 24;
   localparam int CFD_BIT    = 25;
   localparam int DIV_LSB    = 0;
   localparam int PCNT_LSB   = 8;
   localparam int MUL_LSB    = 16;
   localparam int PLL_B29    = 29;
   localparam logic [7:0] MOR_KEY = 8'h37;
   // ----------------------------------------
   // Counts in slow clock cycles
   // ----------------------------------------
   localparam logic [10:0] RC_STARTUP_SLOW = 11'h008;
   localparam logic [8:0]  PLL_CNT_RESET   = 9'h1F8;
   localparam logic [3:0]  MF_LAST_PERIOD  = 4'hF;
   // ----------------------------------------
   // Register selects and measurement states
   // ----------------------------------------
   typedef enum logic [2:0] {
      SEL_NONE  = 3'b000,
      SEL_PCOFF = 3'b001,
      SEL_PCST  = 3'b010,
      SEL_MOR   = 3'b011,
      SEL_MCFR  = 3'b100,
      SEL_PLL   = 3'b101
   } ocp_sel_t;
   typedef enum logic [1:0] {
      MF_IDLE = 2'b00,
      MF_WAIT = 2'b01,
      MF_RUN  = 2'b10
   } ocp_mf_t;
endpackage

/* File: tb/ocp_clock_ctrl_tb.sv */
// Self-checking bench of the oscillator and peripheral clock controller
`timescale 1ns/100ps
`default_nettype none
module ocp_clock_ctrl_tb;
   import ocp_pkg::*;
   logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, slow_clk_pin, main_clk_pin;
   logic [31:0] haddr, hwdata, hrdata, periph_enable_req, periph_clock_run, r;
   logic [1:0]  htrans;
   logic [2:0]  hsize, rc_freq_select;
   logic write_protect_enable, crystal_osc_enable, crystal_osc_bypass, crystal_stable_flag;
   logic rc_osc_enable, rc_stable_flag, main_source_select, clock_fail_detect_enable;
   logic wait_command, pll_lock_flag;
   logic [10:0] pll_multiplier;
   logic [7:0]  pll_divider;
   int n_fail = 0;
   int tests_run = 0;
   ocp_clock_ctrl uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .slow_clk_pin(slow_clk_pin),
      .main_clk_pin(main_clk_pin), .write_protect_enable(write_protect_enable),
      .periph_enable_req(periph_enable_req), .periph_clock_run(periph_clock_run),
      .crystal_osc_enable(crystal_osc_enable), .crystal_osc_bypass(crystal_osc_bypass),
      .crystal_stable_flag(crystal_stable_flag), .rc_osc_enable(rc_osc_enable),
      .rc_freq_select(rc_freq_select), .rc_stable_flag(rc_stable_flag),
      .main_source_select(main_source_select), .wait_command(wait_command),
      .clock_fail_detect_enable(clock_fail_detect_enable), .pll_multiplier(pll_multiplier),
      .pll_divider(pll_divider), .pll_lock_flag(pll_lock_flag));
   ocp_osc_model osc (.crystal_osc_enable(crystal_osc_enable),
      .crystal_osc_bypass(crystal_osc_bypass), .rc_osc_enable(rc_osc_enable),
      .slow_clk_pin(slow_clk_pin), .main_clk_pin(main_clk_pin));
   // ----------------------------------------
   // Shared tasks
   // ----------------------------------------
   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      tests_run++;
      if (got !== exp) begin
         $display("unexpected %s expected %h seen %h", nm, exp, got);
         n_fail++;
      end
   endtask
   task automatic ahb(input logic w, input logic [31:0] a, d, output logic [31:0] rd);
      @(posedge hclk);
      hsel <= 1'b1;
      htrans <= 2'b10;
      haddr <= a;
      hwrite <= w;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      rd = hrdata;
      #1;
   endtask
   function automatic logic flg(int k);
      return k == 0 ? crystal_stable_flag : k == 1 ? rc_stable_flag : pll_lock_flag;
   endfunction
   task automatic win(input int k, lo, hi);
      repeat (lo) @(posedge hclk);
      #1 chk("flag early", 0, flg(k));
      repeat (hi - lo) @(posedge hclk);
      #1 chk("flag late", 1, flg(k));
   endtask
   task automatic results;
      $display("comparisons %0d mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic t_reset;
      ahb(0, ADDR_PLL, 0, r);
      chk("pll_setup", 32'h0000_3F00, r);
      ahb(0, ADDR_MOR, 0, r);
      chk("main_oscillator_control", 32'h0000_0001, r);
      ahb(0, ADDR_PCOFF, 0, r);
      chk("peripheral_clock_off", 32'h0000_0000, r);
      ahb(0, 32'h400E_0500, 0, r);
      chk("unmapped", 32'h0000_0000, r);
      chk("hresp", 0, hresp);
      chk("hreadyout", 1, hreadyout);
   endtask
   task automatic t_gate;
      @(posedge hclk);
      periph_enable_req <= 32'hFFFF_FFFF;
      @(posedge hclk);
      periph_enable_req <= 32'h0000_0000;
      repeat (2) @(posedge hclk);
      chk("run after enable", 32'hFFFF_FFFC, periph_clock_run);
      ahb(1, ADDR_PCOFF, 32'h0000_0031, r);
      chk("run after off", 32'hFFFF_FFCC, periph_clock_run);
      ahb(0, ADDR_PCST, 0, r);
      chk("peripheral_clock_state", 32'hFFFF_FFCC, r);
      @(posedge hclk);
      write_protect_enable <= 1'b1;
      ahb(1, ADDR_PCOFF, 32'hFFFF_FFFF, r);
      chk("run protected", 32'hFFFF_FFCC, periph_clock_run);
      ahb(1, ADDR_MOR, 32'h0037_0000, r);
      chk("xtal protected", 1, crystal_osc_enable);
      @(posedge hclk);
      write_protect_enable <= 1'b0;
      ahb(1, ADDR_MOR, 32'h0036_0009, r);
      chk("rc bad key", 0, rc_osc_enable);
   endtask
   task automatic t_rc;
      for (int c = 0; c < 3; c++) begin
         ahb(1, ADDR_MOR, 32'h0037_0009 | (c << 4), r);
         chk("rc_osc_enable", 1, rc_osc_enable);
         chk("rc_freq_select", c, rc_freq_select);
         if (c == 0)
            win(1, 600, 1000);
      end
      ahb(0, ADDR_MOR, 0, r);
      chk("mor readback", 32'h0000_0029, r);
   endtask
   task automatic t_xtal;
      ahb(1, ADDR_MOR, 32'h0037_0008, r);
      @(posedge hclk);
      #1 chk("xtal flag cleared", 0, crystal_stable_flag);
      ahb(1, ADDR_MOR, 32'h0037_0209, r);
      win(0, 1400, 1800);
      ahb(1, ADDR_MOR, 32'h0337_0209, r);
      chk("main_source_select", 1, main_source_select);
      chk("clock_fail_detect_enable", 1, clock_fail_detect_enable);
      repeat (2000) @(posedge hclk);
      ahb(0, ADDR_MCFR, 0, r);
      chk("main_freq_valid", 1, r[16]);
      chk("main_freq_count", 1, r[15:0] >= 63 && r[15:0] <= 65);
      ahb(1, ADDR_MOR, 32'h0337_020D, r);
      chk("wait pulse", 1, wait_command);
      @(posedge hclk);
      #1 chk("wait pulse end", 0, wait_command);
      ahb(0, ADDR_MOR, 0, r);
      chk("wait bit read", 32'h0300_0209, r);
   endtask
   task automatic t_byp;
      ahb(1, ADDR_MOR, 32'h0137_0000, r);
      @(posedge hclk);
      #1 chk("xtal flag off", 0, crystal_stable_flag);
      repeat (2000) @(posedge hclk);
      ahb(0, ADDR_MCFR, 0, r);
      chk("main_freq_valid off", 0, r[16]);
      ahb(1, ADDR_MOR, 32'h0137_0002, r);
      @(posedge hclk);
      #1 chk("bypass flag", 1, crystal_stable_flag);
      chk("crystal_osc_bypass", 1, crystal_osc_bypass);
   endtask
   task automatic t_pll;
      ahb(1, ADDR_PLL, 32'h2001_0203, r);
      chk("lock cleared", 0, pll_lock_flag);
      chk("pll_multiplier", 1, pll_multiplier);
      chk("pll_divider", 3, pll_divider);
      win(2, 1400, 1800);
      ahb(0, ADDR_PLL, 0, r);
      chk("pll readback", 32'h2001_0203, r);
      ahb(1, ADDR_PLL, 32'h2000_0100, r);
      chk("lock restarted", 0, pll_lock_flag);
      chk("pll off", 0, pll_multiplier);
      chk("divider zero", 0, pll_divider);
      @(posedge hclk);
      write_protect_enable <= 1'b1;
      ahb(1, ADDR_PLL, 32'h2005_0001, r);
      chk("pll protected", 0, pll_multiplier);
      @(posedge hclk);
      write_protect_enable <= 1'b0;
   endtask
   // ----------------------------------------
   // Clock, reset, sequence and watchdog
   // ----------------------------------------
   initial begin
      hclk = 1'b0;
      forever #2 hclk = ~hclk;
   end
   initial begin
      hresetn = 1'b0;
      hsel = 1'b0;
      haddr = 32'h0000_0000;
      htrans = 2'b00;
      hwrite = 1'b0;
      hsize = 3'b010;
      hwdata = 32'h0000_0000;
      write_protect_enable = 1'b0;
      periph_enable_req = 32'h0000_0000;
      repeat (20) @(posedge hclk);
      hresetn <= 1'b1;
      t_reset();
      t_gate();
      t_rc();
      t_xtal();
      t_byp();
      t_pll();
      results();
   end
   initial begin
      repeat (40000) @(posedge hclk);
      n_fail++;
      results();
   end
endmodule
`default_nettype wire

/* File: tb/ocp_osc_model.sv */
// Far-side model: free slow clock and gated main oscillator clock
`timescale 1ns/100ps
`default_nettype none
module ocp_osc_model #(
   parameter int SLOW_HALF = 200,
   parameter int MAIN_HALF = 50
) (
   input  wire logic crystal_osc_enable,
   input  wire logic crystal_osc_bypass,
   input  wire logic rc_osc_enable,
   output logic      slow_clk_pin,
   output logic      main_clk_pin
);
   logic running;
   assign running = crystal_osc_enable | crystal_osc_bypass | rc_osc_enable;
   initial begin
      slow_clk_pin = 1'b0;
      forever #(SLOW_HALF) slow_clk_pin = ~slow_clk_pin;
   end
   // Main clock stands low while no oscillator runs
   initial begin
      main_clk_pin = 1'b0;
      forever #(MAIN_HALF) main_clk_pin = running ? ~main_clk_pin : 1'b0;
   end
endmodule
`default_nettype wire
